/* File: verilog/ssd_buffer.sv */
/*
 * status flags and double-buffered data register of the serial port.
 * assumes the shift engine runs on clk_sys and gives one-cycle
 * start/done pulses; the select pin is asynchronous.
 */
`default_nettype none

module ssd_buffer
    import ssd_pkg::*;
(
    input  wire logic          clk_sys,    // 10 MHz bus clock
    input  wire logic          rst_b,      // synchronous, active low
    input  wire ssd_bus_req_t  bus_req,    // register port request
    output var  logic [7:0]    rd_data,    // read data, cycle after rd
    input  wire ssd_link_in_t  link_in,    // shift engine status
    output var  ssd_link_out_t link_out,   // shift engine load
    input  wire logic          ss_pin_b,   // slave select pin, active low
    output var  logic          master_mode, // master select bit
    output var  logic          irq         // mode fault interrupt
);

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    ssd_state_t st;          // registered state
    ssd_state_t next_st;     // next state

    logic rd_stat;           // status read
    logic rd_lo;             // low data read
    logic rd_hi;             // high data read
    logic wr_lo;             // low data write
    logic wr_hi;             // high data write
    logic wr_c1;             // control one write
    logic wr_stat;           // status write, no effect
    logic wide;              // word transfers selected
    logic fault;             // mode fault detected this cycle
    logic clr_rcv;           // receive flag service event
    logic [15:0] rx_masked;  // incoming word cut to width

    // address match helper
    function automatic logic hit(input logic [SSD_AW-1:0] a,
                                 input logic [SSD_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // strobe decoding
    assign rd_stat = bus_req.rd & hit(bus_req.addr, SSD_OFS_STAT);
    assign rd_lo   = bus_req.rd & hit(bus_req.addr, SSD_OFS_DLO);
    assign rd_hi   = bus_req.rd & hit(bus_req.addr, SSD_OFS_DHI);
    assign wr_lo   = bus_req.wr & hit(bus_req.addr, SSD_OFS_DLO);
    assign wr_hi   = bus_req.wr & hit(bus_req.addr, SSD_OFS_DHI);
    assign wr_c1   = bus_req.wr & hit(bus_req.addr, SSD_OFS_CTRL1);
    assign wr_stat = bus_req.wr & hit(bus_req.addr, SSD_OFS_STAT);

    // width select: zero byte, one word
    assign wide      = st.ctrl2[SSD_C2_WIDE];                    // R22
    assign rx_masked = wide ? link_in.rx_word
                            : {8'h00, link_in.rx_word[7:0]};     // R20

    // select falls while master with detection on
    assign fault = st.ctrl1[SSD_C1_MSTR] & st.ctrl2[SSD_C2_MFDE]
                 & st.ss_prev & ~st.ss_s2;                       // R3

    // low read after armed status read
    assign clr_rcv = rd_lo & st.rcv_armed & st.rcv_flag;         // R6

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st         = st;
        next_st.tx_load = 1'b0;

        // select pin synchroniser, then edge history
        next_st.ss_s1   = ss_pin_b;
        next_st.ss_s2   = st.ss_s1;
        next_st.ss_prev = st.ss_s2;

        // read data mux, zero on idle or unmapped
        next_st.rd_data = 8'h00;
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                SSD_OFS_CTRL1: next_st.rd_data = st.ctrl1;
                SSD_OFS_CTRL2: next_st.rd_data = st.ctrl2;
                SSD_OFS_STAT:                                    // R5
                begin
                    next_st.rd_data[SSD_ST_RCV]  = st.rcv_flag;  // R1
                    next_st.rd_data[SSD_ST_TXE]  = st.tx_empty;  // R2
                    next_st.rd_data[SSD_ST_MODE_FAULT_FLAG] = st.mode_fault_flag;
                end
                SSD_OFS_DHI:   next_st.rd_data = st.rx_data[15:8]; // R14
                SSD_OFS_DLO:   next_st.rd_data = st.rx_data[7:0];  // R13
                default:       next_st.rd_data = 8'h00;
            endcase
        end

        // status read arms whichever flags it saw set
        if (rd_stat)
        begin
            if (st.rcv_flag)
                next_st.rcv_armed = 1'b1;
            if (st.tx_empty)
                next_st.tx_armed = 1'b1;
            if (st.mode_fault_flag)
                next_st.mode_fault_flag_armed = 1'b1;
        end

        // control two simply stores
        if (bus_req.wr && hit(bus_req.addr, SSD_OFS_CTRL2))
            next_st.ctrl2 = bus_req.wdata;

        // ------------------------------------------------------------
        // receive side
        // ------------------------------------------------------------
        // service: held word moves up, otherwise flag drops
        if (clr_rcv)
        begin
            next_st.rcv_armed = 1'b0;
            if (st.hold_valid)
            begin
                next_st.rx_data    = st.rx_hold;                 // R18
                next_st.hold_valid = 1'b0;
            end
            else
                next_st.rcv_flag = 1'b0;                         // R7
        end
        else if (link_in.xfer_start && st.hold_valid)
            next_st.hold_valid = 1'b0;                           // R19

        // completed transfer, set wins over a same-cycle clear
        if (link_in.xfer_done)
        begin
            if (!next_st.rcv_flag)
            begin
                next_st.rx_data  = rx_masked;                    // R16
                next_st.rcv_flag = 1'b1;                         // R1
            end
            else
            begin
                next_st.rx_hold    = rx_masked;                  // R17
                next_st.hold_valid = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // transmit side
        // ------------------------------------------------------------
        // writes only land while the register is empty
        if (st.tx_empty)                                         // R10
        begin
            if (wr_hi)
                next_st.tx_data[15:8] = bus_req.wdata;           // R12
            if (wr_lo)
            begin
                next_st.tx_data[7:0] = bus_req.wdata;
                if (!wide)
                    next_st.tx_data[15:8] = 8'h00;               // R20
                if (st.tx_armed)                                 // R11
                begin
                    next_st.tx_empty = 1'b0;                     // R9
                    next_st.tx_armed = 1'b0;
                end
            end
        end

        // hand queued word to an idle engine at once
        if (!st.tx_empty && !link_in.busy && !st.tx_load)
        begin
            next_st.tx_load  = 1'b1;                             // R15
            next_st.tx_empty = 1'b1;                             // R2
        end

        // ------------------------------------------------------------
        // control one and mode fault
        // ------------------------------------------------------------
        if (wr_c1)
        begin
            next_st.ctrl1 = bus_req.wdata;
            if (st.mode_fault_flag_armed && st.mode_fault_flag)
            begin
                next_st.mode_fault_flag       = 1'b0;                       // R4
                next_st.mode_fault_flag_armed = 1'b0;
            end
        end

        // fault wins over clear and drops to slave mode
        if (fault)
        begin
            next_st.mode_fault_flag               = 1'b1;                   // R3
            next_st.ctrl1[SSD_C1_MSTR] = 1'b0;
        end

        // interrupt request follows flag and enable
        next_st.irq = next_st.mode_fault_flag & next_st.ctrl1[SSD_C1_IE];   // R21
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            st <= SSD_STATE_RST;
        else
            st <= next_st;
    end

    // ----------------------------------------------------------------
    // outputs, all from flops
    // ----------------------------------------------------------------
    assign rd_data          = st.rd_data;
    assign link_out.tx_load = st.tx_load;
    assign link_out.tx_word = st.tx_data;
    assign master_mode      = st.ctrl1[SSD_C1_MSTR];
    assign irq              = st.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // status read reports the flags one cycle later
    stat_read_a: assert property (rd_stat |=> // R1
        rd_data == {$past(st.rcv_flag), 1'b0, $past(st.tx_empty),
                    $past(st.mode_fault_flag), 4'h0})
        else $error("status read data wrong");

    // copy into empty data register
    rcv_set_a: assert property ( // R16
        link_in.xfer_done && !st.rcv_flag && !clr_rcv
        |=> st.rcv_flag && st.rx_data == $past(rx_masked))
        else $error("received word not copied");

    // low read without arming keeps the flag
    rcv_keep_a: assert property ( // R6
        rd_lo && st.rcv_flag && !st.rcv_armed |=> st.rcv_flag)
        else $error("receive flag cleared without status read");

    // high reads never clear
    hi_read_a: assert property (rd_hi && st.rcv_flag |=> st.rcv_flag) // R8
        else $error("high read cleared receive flag");

    // held word moves when serviced in time
    hold_move_a: assert property (clr_rcv && st.hold_valid // R18
        |=> st.rcv_flag && st.rx_data == $past(st.rx_hold))
        else $error("held word not moved");

    // third start drops the held word
    hold_drop_a: assert property ( // R19
        link_in.xfer_start && st.hold_valid && !clr_rcv
        && !link_in.xfer_done |=> !st.hold_valid && $stable(st.rx_data))
        else $error("held word survived third start");

    // writes while full are discarded
    tx_discard_a: assert property ( // R10
        (wr_lo || wr_hi) && !st.tx_empty |=> $stable(st.tx_data))
        else $error("write landed while transmit full");

    // high writes leave empty flag set
    tx_hi_a: assert property (wr_hi && st.tx_empty |=> st.tx_empty) // R12
        else $error("high write cleared empty flag");

    // armed low write queues the word
    tx_clear_a: assert property (wr_lo && st.tx_empty && st.tx_armed // R9
        |=> !st.tx_empty && !st.tx_armed)
        else $error("empty flag not cleared by armed write");

    // queued word goes to idle engine next cycle, one pulse
    tx_start_a: assert property ( // R15
        !st.tx_empty && !link_in.busy && !st.tx_load
        |=> st.tx_load && st.tx_empty ##1 !st.tx_load)
        else $error("queued word not started");

    // status writes change no flag
    stat_ro_a: assert property ( // R5
        wr_stat && !link_in.xfer_done && !link_in.xfer_start && !fault
        && st.tx_empty
        |=> {st.rcv_flag, st.tx_empty, st.mode_fault_flag}
            == $past({st.rcv_flag, st.tx_empty, st.mode_fault_flag}))
        else $error("status write changed a flag");

    // fault sets flag and leaves master mode
    mode_fault_flag_set_a: assert property (fault // R3
        |=> st.mode_fault_flag && !master_mode)
        else $error("mode fault not raised");

    // armed control-one write clears the fault
    mode_fault_flag_clear_a: assert property ( // R4
        wr_c1 && st.mode_fault_flag_armed && st.mode_fault_flag && !fault |=> !st.mode_fault_flag)
        else $error("mode fault not cleared");

    // interrupt with enable
    irq_a: assert property ($rose(st.mode_fault_flag) && st.ctrl1[SSD_C1_IE] // R21
        |-> irq)
        else $error("mode fault interrupt missing");

    rcv_cov_c:  cover property (link_in.xfer_done && !st.rcv_flag);
    hold_cov_c: cover property (clr_rcv && st.hold_valid);
    drop_cov_c: cover property (link_in.xfer_start && st.hold_valid);
    mode_fault_flag_cov_c: cover property (fault ##[1:50] wr_c1 && st.mode_fault_flag_armed);

endmodule

`default_nettype wire

/* File: verilog/ssd_pkg.sv */
/*
 * shared constants, field positions, reset values and carrier structs
 * for the serial status and data buffer.
 * assumes a byte-wide register port and an outside shift engine on the
 * same bus clock.
 */
//
// Overview of operation
// [R1] receive flag in status bit 7 on copy
// [R2] status bit 5 shows transmit register empty
// [R3] mode fault bit 4 on select low as master
// [R4] mode fault clears: status read, then control-one write
// [R5] status readable anytime, writes change nothing
// [R6] receive flag clears: armed status read, low read
// [R7] wide mode low-only read loses high byte
// [R8] high byte reads never touch receive flag
// [R9] empty flag clears: armed status read, low write
// [R10] data writes ignored while transmit not empty
// [R11] wide mode low-only write leaves high undefined
// [R12] high byte writes never touch empty flag
// [R13] read data valid only while receive flag set
// [R14] one data address: reads receive, writes transmit
// [R15] queued word starts right after previous transfer
// [R16] done with flag clear copies word, sets flag
// [R17] second word held while flag still set
// [R18] service before third start moves held word
// [R19] service after third start drops held word
// [R20] transfer width follows control-two width select
// [R21] mode fault with interrupt enable raises interrupt
// [R22] width select zero is byte, one is word
`default_nettype none

package ssd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int         SSD_AW       = 3;       // byte address width
    localparam logic [2:0] SSD_OFS_CTRL1 = 3'h0;   // control register one
    localparam logic [2:0] SSD_OFS_CTRL2 = 3'h1;   // control register two
    localparam logic [2:0] SSD_OFS_STAT  = 3'h3;   // serial_status
    localparam logic [2:0] SSD_OFS_DHI   = 3'h4;   // serial_data_high
    localparam logic [2:0] SSD_OFS_DLO   = 3'h5;   // serial_data_low

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SSD_ST_RCV   = 7;   // receive_complete_flag
    localparam int SSD_ST_TXE   = 5;   // transmit_empty_flag
    localparam int SSD_ST_MODE_FAULT_FLAG  = 4;   // mode_fault_flag
    localparam int SSD_C1_IE    = 7;   // serial_interrupt_enable
    localparam int SSD_C1_MSTR  = 4;   // master mode select
    localparam int SSD_C2_WIDE  = 6;   // transfer_width_select
    localparam int SSD_C2_MFDE  = 4;   // mode_fault_detect_enable

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SSD_AW-1:0] addr;    // byte address
        logic [7:0]        wdata;   // write data
        logic              wr;      // write strobe
        logic              rd;      // read strobe
    } ssd_bus_req_t;

    typedef struct packed {
        logic        xfer_start;    // pulse: shift engine began a transfer
        logic        xfer_done;     // pulse: shift engine finished
        logic        busy;          // engine shifting
        logic [15:0] rx_word;       // received shift register content
    } ssd_link_in_t;

    typedef struct packed {
        logic        tx_load;       // pulse: take tx_word now
        logic [15:0] tx_word;       // queued transmit word
    } ssd_link_out_t;

    // whole module state
    typedef struct packed {
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic        rcv_flag;
        logic        tx_empty;
        logic        mode_fault_flag;
        logic        rcv_armed;
        logic        tx_armed;
        logic        mode_fault_flag_armed;
        logic [15:0] rx_data;
        logic [15:0] rx_hold;
        logic        hold_valid;
        logic [15:0] tx_data;
        logic        tx_load;
        logic        irq;
        logic [7:0]  rd_data;
        logic        ss_s1;
        logic        ss_s2;
        logic        ss_prev;
    } ssd_state_t;

    localparam logic [7:0]  SSD_CTRL1_RST = 8'h00;
    localparam logic [7:0]  SSD_CTRL2_RST = 8'h00;
    localparam logic [15:0] SSD_DATA_RST  = 16'h0000;

    // reset image: transmit register empty, select pin idle high
    localparam ssd_state_t SSD_STATE_RST = '{
        ctrl1: SSD_CTRL1_RST, ctrl2: SSD_CTRL2_RST,
        rcv_flag: 1'b0, tx_empty: 1'b1, mode_fault_flag: 1'b0,
        rcv_armed: 1'b0, tx_armed: 1'b0, mode_fault_flag_armed: 1'b0,
        rx_data: SSD_DATA_RST, rx_hold: SSD_DATA_RST, hold_valid: 1'b0,
        tx_data: SSD_DATA_RST, tx_load: 1'b0, irq: 1'b0, rd_data: 8'h00,
        ss_s1: 1'b1, ss_s2: 1'b1, ss_prev: 1'b1};

endpackage

`default_nettype wire

/* File: dv/ssd_engine_model.sv */
/*
 * behavioural shift engine standing beyond the serial buffer.
 * assumes the buffer's clk_sys and rst_b; the bench starts and ends
 * received transfers through the two tasks below.
 */
`default_nettype none

module ssd_engine_model
    import ssd_pkg::*;
(
    input  wire logic          clk_sys,    // bus clock
    input  wire logic          rst_b,      // synchronous, active low
    input  wire ssd_link_out_t link_out,   // load from the buffer
    output var  ssd_link_in_t  link_in     // engine status
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        m_start = 1'b0;   // bench asks for a start pulse
    logic        m_done  = 1'b0;   // bench asks for a done pulse
    logic [15:0] m_word  = '0;     // word delivered with done
    logic [15:0] last_tx = '0;     // last word taken from the buffer
    int          n_tx    = 0;      // number of loads seen
    int          cnt     = 0;      // cycles left in an auto transfer

    initial link_in = '0;

    // ----------------------------------------------------------------
    // engine: pulses, busy level, word that never holds stale data
    // ----------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        link_in.xfer_start <= 1'b0;
        link_in.xfer_done  <= 1'b0;
        link_in.rx_word    <= ~link_in.rx_word;   // no stale value outside done
        if (!rst_b)
        begin
            link_in.busy <= 1'b0;
            cnt          <= 0;
        end
        else if (link_out.tx_load)
        begin
            // queued word starts at once, busy by the next cycle
            last_tx            <= link_out.tx_word;
            n_tx               <= n_tx + 1;
            cnt                <= 8;
            link_in.busy       <= 1'b1;
            link_in.xfer_start <= 1'b1;
        end
        else if (cnt == 1)
        begin
            // echo: the answer is the inverse of what was sent
            cnt               <= 0;
            link_in.busy      <= 1'b0;
            link_in.xfer_done <= 1'b1;
            link_in.rx_word   <= ~last_tx;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
        else if (m_start)
        begin
            link_in.busy       <= 1'b1;
            link_in.xfer_start <= 1'b1;
        end
        else if (m_done)
        begin
            link_in.busy      <= 1'b0;
            link_in.xfer_done <= 1'b1;
            link_in.rx_word   <= m_word;
        end
    end

    // start of an externally clocked transfer
    task automatic begin_xfer();
        @(posedge clk_sys);
        m_start <= 1'b1;
        @(posedge clk_sys);
        m_start <= 1'b0;
    endtask

    // end of that transfer with the word received
    task automatic end_xfer(input logic [15:0] w);
        @(posedge clk_sys);
        m_done <= 1'b1;
        m_word <= w;
        @(posedge clk_sys);
        m_done <= 1'b0;
    endtask

endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
/*
 * self-checking bench for the serial status and data buffer.
 * assumes the engine model beside it; reads are scored by a monitor
 * that takes notes from a queue one cycle after each read strobe.
 */
`default_nettype none

module tb_top;
    import ssd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic          clk_sys  = 1'b0;   // 10 MHz
    logic          rst_b    = 1'b0;   // held low at start
    ssd_bus_req_t  bus_req  = '0;     // register port
    logic [7:0]    rd_data;           // read answer
    ssd_link_in_t  link_in;           // engine status
    ssd_link_out_t link_out;          // engine load
    logic          ss_pin_b = 1'b1;   // select idle high
    logic          master_mode;       // master bit
    logic          irq;               // fault interrupt
    logic [7:0]    exp_q[$];          // expected read data notes
    logic          rd_d     = 1'b0;   // read issued last cycle
    int            n_mismatch = 0;
    int            compares   = 0;
    logic [15:0]   w1, w2, w3;        // random received words

    always #50 clk_sys = ~clk_sys;

    ssd_buffer u_ssd_buffer (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
        .rd_data(rd_data), .link_in(link_in), .link_out(link_out),
        .ss_pin_b(ss_pin_b), .master_mode(master_mode), .irq(irq));

    ssd_engine_model u_ssd_engine_model (.clk_sys(clk_sys), .rst_b(rst_b),
        .link_out(link_out), .link_in(link_in));

    // ----------------------------------------------------------------
    // bus tasks and direct compare
    // ----------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        exp_q.push_back(e);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // monitor: read data stands in the cycle after the strobe
    // ----------------------------------------------------------------
    always @(posedge clk_sys)
        rd_d <= bus_req.rd;

    always @(negedge clk_sys)
    begin
        if (rd_d)
        begin
            if (exp_q.size() == 0)
                chk("read note", 16'h0000, 16'hFFFF);
            else
                chk("rd_data", {8'h00, exp_q.pop_front()}, {8'h00, rd_data});
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32869));
        w1 = 16'($urandom);
        w2 = 16'($urandom);
        w3 = 16'($urandom);
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        // reset image, status writes ignored, unmapped read
        rd(SSD_OFS_STAT, 8'h20);
        wr(SSD_OFS_STAT, 8'hFF);
        rd(SSD_OFS_STAT, 8'h20);
        rd(3'h2, 8'h00);
        // byte width: low read needs an armed status read
        u_ssd_engine_model.begin_xfer();
        u_ssd_engine_model.end_xfer(w1);
        rd(SSD_OFS_DLO, w1[7:0]);
        rd(SSD_OFS_STAT, 8'hA0);
        rd(SSD_OFS_DHI, 8'h00);
        rd(SSD_OFS_STAT, 8'hA0);
        rd(SSD_OFS_DLO, w1[7:0]);
        rd(SSD_OFS_STAT, 8'h20);
        // word width: overrun with service after the third start
        wr(SSD_OFS_CTRL2, 8'h40);
        u_ssd_engine_model.begin_xfer();
        u_ssd_engine_model.end_xfer(w1);
        u_ssd_engine_model.begin_xfer();
        u_ssd_engine_model.end_xfer(w2);
        rd(SSD_OFS_DHI, w1[15:8]);
        u_ssd_engine_model.begin_xfer();
        rd(SSD_OFS_STAT, 8'hA0);
        rd(SSD_OFS_DHI, w1[15:8]);
        rd(SSD_OFS_DLO, w1[7:0]);
        rd(SSD_OFS_STAT, 8'h20);
        u_ssd_engine_model.end_xfer(w3);
        rd(SSD_OFS_STAT, 8'hA0);
        rd(SSD_OFS_DHI, w3[15:8]);
        rd(SSD_OFS_DLO, w3[7:0]);
        // transmit while the engine is busy, late writes dropped
        wr(SSD_OFS_CTRL1, 8'h10);
        u_ssd_engine_model.begin_xfer();
        chk("master_mode", 16'h0001, {15'h0, master_mode});
        rd(SSD_OFS_STAT, 8'h20);
        wr(SSD_OFS_DHI, 8'h5A);
        wr(SSD_OFS_DLO, 8'hC3);
        rd(SSD_OFS_STAT, 8'h00);
        wr(SSD_OFS_DLO, 8'h11);
        wr(SSD_OFS_DHI, 8'h22);
        rd(SSD_OFS_STAT, 8'h00);
        u_ssd_engine_model.end_xfer(w2);
        for (int i = 0; i < 40 && u_ssd_engine_model.n_tx == 0; i++)
            @(posedge clk_sys);
        chk("tx loads", 16'h0001, 16'(u_ssd_engine_model.n_tx));
        chk("tx_word", 16'h5AC3, u_ssd_engine_model.last_tx);
        repeat (12) @(posedge clk_sys);
        // echo word is held behind w2, moves in on service
        rd(SSD_OFS_STAT, 8'hA0);
        rd(SSD_OFS_DHI, w2[15:8]);
        rd(SSD_OFS_DLO, w2[7:0]);
        rd(SSD_OFS_STAT, 8'hA0);
        rd(SSD_OFS_DHI, 8'hA5);
        rd(SSD_OFS_DLO, 8'h3C);
        // select low with detection off, then on
        @(posedge clk_sys);
        ss_pin_b <= 1'b0;
        repeat (6) @(posedge clk_sys);
        ss_pin_b <= 1'b1;
        rd(SSD_OFS_STAT, 8'h20);
        wr(SSD_OFS_CTRL2, 8'h50);
        wr(SSD_OFS_CTRL1, 8'h90);
        ss_pin_b <= 1'b0;
        repeat (6) @(posedge clk_sys);
        ss_pin_b <= 1'b1;
        chk("irq", 16'h0001, {15'h0, irq});
        wr(SSD_OFS_CTRL1, 8'h90);
        rd(SSD_OFS_STAT, 8'h30);
        wr(SSD_OFS_CTRL1, 8'h80);
        rd(SSD_OFS_STAT, 8'h20);
        repeat (2) @(posedge clk_sys);
        chk("irq", 16'h0000, {15'h0, irq});
        chk("read notes left", 16'h0000, 16'(exp_q.size()));
        stop_test();
    end

endmodule

`default_nettype wire
